/* File: logic/vescp_line_sync.sv */
// Two-stage synchronisers for the bus pins and the strap, with edge and condition detection.
module vescp_line_sync
    import vescp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclPin,
    input wire logic sdaPin,
    input wire logic strapPin,
    output logic sclRise,
    output logic sclFall,
    output logic sdaLevel,
    output logic strapLevel,
    output logic startDet,
    output logic stopDet
);

    logic [2:0] meta_reg;
    logic [2:0] meta_next;
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic [1:0] prev_reg;
    logic [1:0] prev_next;

    // Bit 2 is the clock line, bit 1 the data line, bit 0 the strap.
    always_comb begin
        meta_next = {sclPin, sdaPin, strapPin};
        sync_next = meta_reg;
        prev_next = sync_reg[2:1];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= 3'h7;
            sync_reg <= 3'h7;
            prev_reg <= 2'h3;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    assign sclRise = sync_reg[2] & ~prev_reg[1];
    assign sclFall = ~sync_reg[2] & prev_reg[1];
    assign sdaLevel = sync_reg[1];
    assign strapLevel = sync_reg[0];
    // Data changing while the clock stays high marks a start or a stop.
    assign startDet = sync_reg[2] & prev_reg[1] & prev_reg[0] & ~sync_reg[1];
    assign stopDet = sync_reg[2] & prev_reg[1] & ~prev_reg[0] & sync_reg[1];

endmodule : vescp_line_sync

/* File: logic/vescp_pkg.sv */
// Constants, encodings and states shared by the serial control port files.
// Function
// - First byte holds seven address bits then a direction bit, one meaning read.
// - Two slave addresses; address bit one follows the address select pin.
// - A start is data falling while clock is high; it is recognised.
// - After a start, eight bits are shifted in most significant bit first.
// - On an address match the device pulls data low in the ninth pulse.
// - On a mismatch the device releases the bus and waits for a start.
// - First byte is the device address, second byte the starting register index.
// - The register index increments after every data byte read or written, stopping at one past the last register.
// - A stop at any point sends the port straight back to idle; a start begins a new address byte.
// - An invalid register index gets no acknowledge and the port goes idle.
// - Reads past the last register keep returning the last register until no acknowledge.
// - Writes past the last register store nothing, get no acknowledge, go idle.
// - Every write first loads the write-only pointer; a read starts from it; other registers are read-write.
// - A two-bit field in register zero selects the output video standard.
// - A three-bit field in register zero selects the luma filter.
// - A three-bit field in register zero selects the chroma filter.
// - Six bits in register one power down the six converters individually.
// - The oversampling bit in register one enables four-times oversampling.
package vescp_pkg;

    localparam logic [7:0] STD_FILTER_OFFSET = 8'h00;
    localparam logic [7:0] DAC_CTRL_OFFSET = 8'h01;
    localparam logic [7:0] LAST_REG_INDEX = 8'h01;

    localparam logic [7:0] STD_FILTER_RESET = 8'h00;
    localparam logic [7:0] DAC_CTRL_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;

    localparam int OUTPUT_STANDARD_LSB = 0;
    localparam int OUTPUT_STANDARD_MSB = 1;
    localparam int LUMA_FILTER_LSB = 2;
    localparam int LUMA_FILTER_MSB = 4;
    localparam int CHROMA_FILTER_LSB = 5;
    localparam int CHROMA_FILTER_MSB = 7;
    localparam int DAC_POWERDOWN_LSB = 0;
    localparam int DAC_POWERDOWN_MSB = 5;
    localparam int QUAD_OVERSAMPLE_BIT = 6;
    localparam int RESERVED_ZERO_BIT = 7;

    localparam logic [1:0] STANDARD_NTSC = 2'h0;
    localparam logic [1:0] STANDARD_PAL_BDGHI = 2'h1;
    localparam logic [1:0] STANDARD_PAL_M = 2'h2;
    localparam logic [1:0] STANDARD_PAL_N = 2'h3;

    localparam int ADDRESS_BIT_ONE_POS = 1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_COUNT_ONE = 4'h1;
    localparam logic [7:0] POINTER_STEP = 8'h01;
    localparam logic SDA_DRIVE_LEVEL = 1'b0;

    typedef enum logic [8:0] {
        VESCP_IDLE = 9'h001,
        VESCP_ADDR = 9'h002,
        VESCP_ADDR_ACK = 9'h004,
        VESCP_PTR = 9'h008,
        VESCP_PTR_ACK = 9'h010,
        VESCP_WDATA = 9'h020,
        VESCP_WDATA_ACK = 9'h040,
        VESCP_RDATA = 9'h080,
        VESCP_RDATA_ACK = 9'h100
    } vescp_state_t;

endpackage : vescp_pkg

/* File: logic/vescp_serial_port.sv */
// Two-wire serial control port slave holding the standard, filter and converter control registers.
module vescp_serial_port
    import vescp_pkg::*;
#(
    // Arbitrary base address; bit one is replaced by the address select pin.
    parameter logic [6:0] DEVICE_ADDRESS_BASE = 7'h54
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addressSelectPin,
    output logic [1:0] outputStandard,
    output logic [2:0] lumaFilter,
    output logic [2:0] chromaFilter,
    output logic [5:0] dacPowerdown,
    output logic quadOversample,
    output logic busBusy
);

    logic sclRise;
    logic sclFall;
    logic sdaLevel;
    logic strapLevel;
    logic startDet;
    logic stopDet;

    vescp_state_t state_reg;
    vescp_state_t state_next;
    vescp_state_t after_reg;
    vescp_state_t after_next;
    logic [3:0] bitCount_reg;
    logic [3:0] bitCount_next;
    logic [7:0] rxShift_reg;
    logic [7:0] rxShift_next;
    logic [7:0] txShift_reg;
    logic [7:0] txShift_next;
    logic [7:0] pointer_reg;
    logic [7:0] pointer_next;
    logic [7:0] stdFilter_reg;
    logic [7:0] stdFilter_next;
    logic [7:0] dacCtrl_reg;
    logic [7:0] dacCtrl_next;
    logic sdaOe_reg;
    logic sdaOe_next;
    logic hostAck_reg;
    logic hostAck_next;
    logic [6:0] ownAddress;
    logic [7:0] rxByte;

    vescp_line_sync u_line_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .sclPin(sclIn),
        .sdaPin(sdaIn),
        .strapPin(addressSelectPin),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .sdaLevel(sdaLevel),
        .strapLevel(strapLevel),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    // An index names a register only when it lies within the implemented range.
    function automatic logic indexValid(input logic [7:0] index);
        indexValid = (index <= LAST_REG_INDEX);
    endfunction : indexValid

    // Reads beyond the last register return the last register again.
    function automatic logic [7:0] readRegister(input logic [7:0] index, input logic [7:0] reg0,
                                               input logic [7:0] reg1);
        if (index == STD_FILTER_OFFSET) begin
            readRegister = reg0;
        end else begin
            readRegister = reg1;
        end
    endfunction : readRegister

    always_comb begin
        ownAddress = DEVICE_ADDRESS_BASE;
        ownAddress[ADDRESS_BIT_ONE_POS] = strapLevel;
    end

    // The byte shifted in on earlier rising edges, not yet including a bit sampled on the current one.
    assign rxByte = rxShift_reg;

    always_comb begin
        state_next = state_reg;
        after_next = after_reg;
        bitCount_next = bitCount_reg;
        rxShift_next = rxShift_reg;
        txShift_next = txShift_reg;
        pointer_next = pointer_reg;
        stdFilter_next = stdFilter_reg;
        dacCtrl_next = dacCtrl_reg;
        sdaOe_next = sdaOe_reg;
        hostAck_next = hostAck_reg;

        if (startDet) begin
            // A start, expected or not, always begins a fresh address byte.
            state_next = VESCP_ADDR;
            bitCount_next = BIT_COUNT_ZERO;
            sdaOe_next = 1'b0;
        end else if (stopDet) begin
            state_next = VESCP_IDLE;
            sdaOe_next = 1'b0;
        end else begin
            unique case (state_reg)
                VESCP_IDLE: begin
                    sdaOe_next = 1'b0;
                end
                VESCP_ADDR, VESCP_PTR, VESCP_WDATA: begin
                    if (sclRise && bitCount_reg < BITS_PER_BYTE) begin
                        rxShift_next = {rxShift_reg[6:0], sdaLevel};
                        bitCount_next = bitCount_reg + BIT_COUNT_ONE;
                    end else if (sclFall && bitCount_reg == BITS_PER_BYTE) begin
                        unique case (state_reg)
                            VESCP_ADDR: begin
                                if (rxByte[7:1] == ownAddress) begin
                                    sdaOe_next = 1'b1;
                                    state_next = VESCP_ADDR_ACK;
                                    // A read continues from the pointer left by an earlier write.
                                    after_next = rxByte[0] ? VESCP_RDATA : VESCP_PTR;
                                end else begin
                                    state_next = VESCP_IDLE;
                                end
                            end
                            VESCP_PTR: begin
                                if (indexValid(rxByte)) begin
                                    pointer_next = rxByte;
                                    sdaOe_next = 1'b1;
                                    state_next = VESCP_PTR_ACK;
                                    after_next = VESCP_WDATA;
                                end else begin
                                    state_next = VESCP_IDLE;
                                end
                            end
                            default: begin
                                if (indexValid(pointer_reg)) begin
                                    if (pointer_reg == STD_FILTER_OFFSET) begin
                                        stdFilter_next = rxByte;
                                    end else begin
                                        dacCtrl_next = rxByte;
                                    end
                                    pointer_next = pointer_reg + POINTER_STEP;
                                    sdaOe_next = 1'b1;
                                    state_next = VESCP_WDATA_ACK;
                                    after_next = VESCP_WDATA;
                                end else begin
                                    state_next = VESCP_IDLE;
                                end
                            end
                        endcase
                    end
                end
                VESCP_ADDR_ACK, VESCP_PTR_ACK, VESCP_WDATA_ACK: begin
                    if (sclFall) begin
                        bitCount_next = BIT_COUNT_ZERO;
                        state_next = after_reg;
                        if (after_reg == VESCP_RDATA) begin
                            txShift_next = readRegister(pointer_reg, stdFilter_reg, dacCtrl_reg);
                            sdaOe_next = ~txShift_next[7];
                            if (indexValid(pointer_reg)) begin
                                pointer_next = pointer_reg + POINTER_STEP;
                            end
                        end else begin
                            sdaOe_next = 1'b0;
                        end
                    end
                end
                VESCP_RDATA: begin
                    if (sclRise && bitCount_reg < BITS_PER_BYTE) begin
                        bitCount_next = bitCount_reg + BIT_COUNT_ONE;
                    end else if (sclFall && bitCount_reg == BITS_PER_BYTE) begin
                        sdaOe_next = 1'b0;
                        hostAck_next = 1'b0;
                        state_next = VESCP_RDATA_ACK;
                    end else if (sclFall && bitCount_reg != BIT_COUNT_ZERO) begin
                        txShift_next = {txShift_reg[6:0], 1'b0};
                        sdaOe_next = ~txShift_reg[6];
                    end
                end
                VESCP_RDATA_ACK: begin
                    if (sclRise) begin
                        hostAck_next = ~sdaLevel;
                    end else if (sclFall) begin
                        if (hostAck_reg) begin
                            bitCount_next = BIT_COUNT_ZERO;
                            state_next = VESCP_RDATA;
                            txShift_next = readRegister(pointer_reg, stdFilter_reg, dacCtrl_reg);
                            sdaOe_next = ~txShift_next[7];
                            if (indexValid(pointer_reg)) begin
                                pointer_next = pointer_reg + POINTER_STEP;
                            end
                        end else begin
                            sdaOe_next = 1'b0;
                            state_next = VESCP_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = VESCP_IDLE;
                    sdaOe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= VESCP_IDLE;
            after_reg <= VESCP_IDLE;
            bitCount_reg <= BIT_COUNT_ZERO;
            rxShift_reg <= 8'h00;
            txShift_reg <= 8'h00;
            pointer_reg <= POINTER_RESET;
            stdFilter_reg <= STD_FILTER_RESET;
            dacCtrl_reg <= DAC_CTRL_RESET;
            sdaOe_reg <= 1'b0;
            hostAck_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            after_reg <= after_next;
            bitCount_reg <= bitCount_next;
            rxShift_reg <= rxShift_next;
            txShift_reg <= txShift_next;
            pointer_reg <= pointer_next;
            stdFilter_reg <= stdFilter_next;
            dacCtrl_reg <= dacCtrl_next;
            sdaOe_reg <= sdaOe_next;
            hostAck_reg <= hostAck_next;
        end
    end

    // The pin is open drain: it is only ever pulled low.
    assign sdaOut = SDA_DRIVE_LEVEL;
    assign sdaOe = sdaOe_reg;
    assign busBusy = (state_reg != VESCP_IDLE);

    assign outputStandard = stdFilter_reg[OUTPUT_STANDARD_MSB:OUTPUT_STANDARD_LSB];
    assign lumaFilter = stdFilter_reg[LUMA_FILTER_MSB:LUMA_FILTER_LSB];
    assign chromaFilter = stdFilter_reg[CHROMA_FILTER_MSB:CHROMA_FILTER_LSB];
    assign dacPowerdown = dacCtrl_reg[DAC_POWERDOWN_MSB:DAC_POWERDOWN_LSB];
    assign quadOversample = dacCtrl_reg[QUAD_OVERSAMPLE_BIT];

endmodule : vescp_serial_port

/* File: tb/vescp_host_model.sv */
// Bus master model driving the clock and data lines; released data reads high through the pull-up.
module vescp_host_model (
    output logic scl,
    output logic sda,
    input wire logic busSda
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // One 160 ns bit cell: data moves early in the low phase and is read late in the high phase.
    task automatic bit_x(input logic b, output logic r);
        #20 sda = b;
        #60 scl = 1'b1;
        #60 r = busSda;
        #20 scl = 1'b0;
    endtask : bit_x

    task automatic start_cond();
        #60 sda = 1'b1;
        #60 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #20 sda = 1'b0;
        #60 scl = 1'b1;
        #40 sda = 1'b1;
        #40;
    endtask : stop_cond

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask : rd_byte
endmodule : vescp_host_model

/* File: tb/vescp_serial_port_bench.sv */
// Self-checking bench for the serial control port driven through a bus master model.
module vescp_serial_port_bench;
    import vescp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [6:0] BASE_ADDR = 7'h54;
    logic clk;
    logic sys_rst;
    logic addressSelectPin;
    logic sclW;
    logic hostSda;
    logic sdaW;
    logic sdaOut;
    logic sdaOe;
    logic busBusy;
    logic quadOversample;
    logic [1:0] outputStandard;
    logic [2:0] lumaFilter;
    logic [2:0] chromaFilter;
    logic [5:0] dacPowerdown;
    logic ackSeen;
    logic [7:0] rdData;
    // Both indexes lie past the last register while keeping the pointer's top bit at zero.
    logic [7:0] badPtr [2] = '{8'h02, 8'h7F};
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    assign sdaW = hostSda & (~sdaOe | sdaOut);

    vescp_serial_port #(.DEVICE_ADDRESS_BASE(BASE_ADDR)) i_vescp_serial_port (.clk(clk), .sys_rst(sys_rst),
        .sclIn(sclW), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelectPin(addressSelectPin),
        .outputStandard(outputStandard), .lumaFilter(lumaFilter), .chromaFilter(chromaFilter),
        .dacPowerdown(dacPowerdown), .quadOversample(quadOversample), .busBusy(busBusy));
    vescp_host_model i_vescp_host_model (.scl(sclW), .sda(hostSda), .busSda(sdaW));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] dev(input logic pin, input logic rd);
        return {BASE_ADDR[6:2], pin, BASE_ADDR[0], rd};
    endfunction : dev

    task automatic send(input logic [7:0] d, input logic expAck);
        i_vescp_host_model.wr_byte(d, ackSeen);
        check("acknowledge", {7'h00, ackSeen}, {7'h00, expAck});
    endtask : send

    task automatic busy_is(input logic exp);
        repeat (8) @(posedge clk);
        #2 check("busy", {7'h00, busBusy}, {7'h00, exp});
    endtask : busy_is

    initial begin
        sys_rst = 1'b1;
        addressSelectPin = 1'b0;
        repeat (2) @(posedge clk);
        #2 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        #2 check("standard", {6'h00, outputStandard}, 8'h00);
        check("filters", {2'h0, lumaFilter, chromaFilter}, 8'h00);
        check("dac", {1'b0, quadOversample, dacPowerdown}, 8'h00);
        // Burst write that runs past the last register.
        i_vescp_host_model.start_cond();
        send(dev(1'b0, 1'b0), 1'b1);
        send(8'h00, 1'b1);
        send(8'hA5, 1'b1);
        send(8'h7E, 1'b1);
        send(8'h33, 1'b0);
        busy_is(1'b0);
        i_vescp_host_model.stop_cond();
        check("standard", {6'h00, outputStandard}, 8'h01);
        check("filters", {2'h0, lumaFilter, chromaFilter}, 8'h0D);
        check("dac", {1'b0, quadOversample, dacPowerdown}, 8'h7E);
        // Pointer load, repeated start, then a read that runs past the last register.
        i_vescp_host_model.start_cond();
        send(dev(1'b0, 1'b0), 1'b1);
        send(8'h00, 1'b1);
        i_vescp_host_model.start_cond();
        send(dev(1'b0, 1'b1), 1'b1);
        for (int i = 0; i < 4; i++) begin
            i_vescp_host_model.rd_byte(i == 3, rdData);
            check("read data", rdData, (i == 0) ? 8'hA5 : 8'h7E);
        end
        busy_is(1'b0);
        i_vescp_host_model.stop_cond();
        // Strap moves address bit one; the old address is ignored.
        @(posedge clk);
        #2 addressSelectPin = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        i_vescp_host_model.start_cond();
        send(dev(1'b0, 1'b0), 1'b0);
        busy_is(1'b0);
        foreach (badPtr[i]) begin
            i_vescp_host_model.start_cond();
            send(dev(1'b1, 1'b0), 1'b1);
            send(badPtr[i], 1'b0);
            busy_is(1'b0);
        end
        // Stop in the middle of a data byte leaves the register untouched.
        i_vescp_host_model.start_cond();
        send(dev(1'b1, 1'b0), 1'b1);
        send(8'h01, 1'b1);
        for (int i = 0; i < 4; i++) begin
            i_vescp_host_model.bit_x(1'b0, ackSeen);
        end
        i_vescp_host_model.stop_cond();
        busy_is(1'b0);
        check("dac", {1'b0, quadOversample, dacPowerdown}, 8'h7E);
        // Single register writes select every output standard.
        for (int s = 0; s < 4; s++) begin
            i_vescp_host_model.start_cond();
            send(dev(1'b1, 1'b0), 1'b1);
            send(8'h00, 1'b1);
            send({6'h00, s[1:0]}, 1'b1);
            i_vescp_host_model.stop_cond();
            busy_is(1'b0);
            check("standard", {6'h00, outputStandard}, {6'h00, s[1:0]});
        end
        stop_test();
    end
endmodule : vescp_serial_port_bench

/* File: tb/vescp_serial_port_props.sv */
// Concurrent checks on the serial control port pins and control outputs.
module vescp_serial_port_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic addressSelectPin,
    input wire logic [1:0] outputStandard,
    input wire logic [2:0] lumaFilter,
    input wire logic [2:0] chromaFilter,
    input wire logic [5:0] dacPowerdown,
    input wire logic quadOversample,
    input wire logic busBusy
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    drive_level_a: assert property (sdaOe |-> sdaOut == 1'b0)
        else $error("data line driven high");
    start_busy_a: assert property ($fell(sdaIn) && sclIn && $past(sclIn) |-> ##[1:8] busBusy)
        else $error("start not seen");
    stop_idle_a: assert property ($rose(sdaIn) && sclIn && $past(sclIn) |-> ##[1:8] !busBusy)
        else $error("stop did not idle the port");
    ack_steady_a: assert property ($rose(sdaOe) |-> sdaOe [*7])
        else $error("drive shorter than a bit time");
    drive_rise_low_a: assert property ($rose(sdaOe) |-> !$past(sclIn, 3))
        else $error("drive began outside clock low");
    drive_fall_low_a: assert property ($fell(sdaOe) |-> !$past(sclIn, 3))
        else $error("drive ended outside clock low");
    idle_release_a: assert property (!busBusy |-> !sdaOe)
        else $error("idle port drives data");
    fields_busy_a: assert property ($changed({outputStandard, lumaFilter, chromaFilter, dacPowerdown,
        quadOversample}) |-> $past(busBusy))
        else $error("control field changed while idle");
endmodule : vescp_serial_port_props

bind vescp_serial_port vescp_serial_port_props i_vescp_serial_port_props (.clk(clk), .sys_rst(sys_rst),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelectPin(addressSelectPin),
    .outputStandard(outputStandard), .lumaFilter(lumaFilter), .chromaFilter(chromaFilter),
    .dacPowerdown(dacPowerdown), .quadOversample(quadOversample), .busBusy(busBusy));
